/* File: csl_dynamic_ops.sv */
// Working stack with compare, select, lag, lead and dead-time delay operations
module csl_dynamic_ops #(
	parameter int INTERVAL_MS = csl_pkg::INTERVAL_MS_DEF
)(
	input  logic                mclk,
	input  logic                srst,
	input  csl_pkg::csl_req_t   req,
	output csl_pkg::csl_stack_t stack_r,
	output logic                done_r
);
	import csl_pkg::*;

	localparam logic signed [47:0] DT_S  = 48'(INTERVAL_MS);
	localparam logic [31:0]        DT_U  = 32'(INTERVAL_MS);
	localparam logic [5:0]         DEP_U = 6'(DEPTH);

	csl_stack_t          stack_nxt;
	logic signed [W-1:0] lag_r [LAG_INSTANCES];
	logic signed [W-1:0] lead_r [LAG_INSTANCES];
	logic signed [W-1:0] buf_r [DEPTH];
	logic [31:0]         acc_r;
	logic                primed_r;

	// Filter step shared by lag and lead; T clamps to its documented range
	function automatic logic signed [W-1:0] lag_step(
		input logic signed [W-1:0] y,
		input logic signed [W-1:0] x,
		input logic signed [W-1:0] t
	);
		logic signed [47:0] tms;
		logic signed [47:0] num;
		tms = (t < 0) ? 48'sh0 : ((t > LAG_T_MAX) ? 48'(LAG_T_MAX) : 48'(t));
		tms = tms * 48'(LAG_MS_PER_LSB);
		num = (48'(x) - 48'(y)) * DT_S;
		return W'(48'(y) + num / (tms + DT_S));
	endfunction

	wire logic signed [W-1:0] top    = stack_r.top;
	wire logic signed [W-1:0] sec    = stack_r.second;
	wire logic signed [W-1:0] thd    = stack_r.third;
	wire logic                fire   = req.valid;
	wire logic                inst_ok = 32'(req.inst) < LAG_INSTANCES;
	wire logic                is_lag  = fire && req.code == OP_LAG && inst_ok;
	wire logic                is_lead = fire && req.code == OP_LEAD && inst_ok;
	wire logic                is_dly  = fire && req.code == OP_DELAY;

	// Comparison and selection
	wire logic signed [W-1:0] cmp_res = (top <= sec) ? W'(ONE) : '0;
	wire logic signed [W-1:0] sel_res = (top < HALF) ? thd : sec;

	// Filter results for the addressed instance
	wire logic signed [W-1:0] lag_new  = lag_step(lag_r[req.inst], sec, top);
	wire logic signed [W-1:0] lead_new = lag_step(lead_r[req.inst], sec, top);
	wire logic signed [W-1:0] lead_out = sec - lead_new;

	// Dead time in whole seconds, clamped
	wire logic [31:0] lsec = (top < 0) ? 32'h0 :
		((top > DEAD_T_MAX) ? 32'(DEAD_T_MAX) : 32'(top));
	wire logic [31:0] per_ideal = lsec * 32'(DEAD_PER_MS_LSB);
	wire logic        per_short = per_ideal < DT_U;
	wire logic [31:0] period    = per_short ? DT_U : per_ideal;
	wire logic [31:0] short_dep = (lsec * 32'(DEAD_MS_PER_LSB)) / DT_U;
	wire logic [5:0]  depth     = !per_short ? DEP_U :
		((short_dep == 32'h0) ? 6'h01 : 6'(short_dep));
	wire logic [31:0] acc_step  = acc_r + DT_U;
	wire logic        shift     = acc_step >= period;
	wire logic signed [W-1:0] tap_old = buf_r[depth - 6'h01];
	wire logic signed [W-1:0] tap_new = (depth > 6'h01) ? buf_r[depth - 6'h02] : sec;
	wire logic signed [63:0]  tap_dif = 64'(tap_new) - 64'(tap_old);
	wire logic signed [63:0]  tap_ip  = (tap_dif * $signed({32'h0, acc_step}))
		/ $signed({32'h0, period});
	wire logic signed [W-1:0] dly_out = !primed_r ? sec :
		(shift ? tap_new : W'(64'(tap_old) + tap_ip));

	always_comb
	begin
		stack_nxt = stack_r;
		if (fire)
		begin
			case (req.code)
				OP_LOAD:
				begin
					stack_nxt.third  = sec;
					stack_nxt.second = top;
					stack_nxt.top    = req.value;
				end
				OP_COMPARE: stack_nxt.top = cmp_res;
				OP_SELECT:  stack_nxt.top = sel_res;
				OP_LAG:     stack_nxt.top = inst_ok ? lag_new : top;
				OP_LEAD:    stack_nxt.top = inst_ok ? lead_out : top;
				OP_DELAY:   stack_nxt.top = dly_out;
				default:    stack_nxt = stack_r;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			stack_r <= '0;
			done_r  <= 1'b0;
		end
		else
		begin
			stack_r <= stack_nxt;
			done_r  <= fire;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			for (int i = 0; i < LAG_INSTANCES; i++)
			begin
				lag_r[i]  <= '0;
				lead_r[i] <= '0;
			end
		end
		else
		begin
			if (is_lag)
				lag_r[req.inst] <= lag_new;
			if (is_lead)
				lead_r[req.inst] <= lead_new;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			primed_r <= 1'b0;
			acc_r    <= '0;
			for (int i = 0; i < DEPTH; i++)
				buf_r[i] <= '0;
		end
		else if (is_dly)
		begin
			if (!primed_r)
			begin
				primed_r <= 1'b1;
				acc_r    <= '0;
				for (int i = 0; i < DEPTH; i++)
					buf_r[i] <= sec;
			end
			else if (shift)
			begin
				acc_r    <= '0;
				buf_r[0] <= sec;
				for (int i = 1; i < DEPTH; i++)
					buf_r[i] <= buf_r[i-1];
			end
			else
				acc_r <= acc_step;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	cmp_result_a: assert property (fire && req.code == OP_COMPARE |=>
		stack_r.top == (($past(top) <= $past(sec)) ? W'(ONE) : W'(0)))
		else $error("compare result wrong");
	cmp_keep_a: assert property (fire && req.code == OP_COMPARE |=>
		$stable(stack_r.second) && $stable(stack_r.third))
		else $error("compare disturbed lower entries");
	sel_low_a: assert property (fire && req.code == OP_SELECT && top < HALF |=>
		stack_r.top == $past(thd))
		else $error("select low picked wrong entry");
	sel_high_a: assert property (fire && req.code == OP_SELECT && top >= HALF |=>
		stack_r.top == $past(sec))
		else $error("select high picked wrong entry");
	load_push_a: assert property (fire && req.code == OP_LOAD |=>
		stack_r.third == $past(sec) && stack_r.second == $past(top)
		&& stack_r.top == $past(req.value))
		else $error("load did not push");
	lag_zero_a: assert property (is_lag && top <= 0 |=>
		stack_r.top == $past(sec) && done_r)
		else $error("zero time constant lag not transparent");
	lead_gain_a: assert property (is_lead ##1 !fire |->
		stack_r.top + lead_r[$past(req.inst)] == $past(sec))
		else $error("lead output not input minus lag");
	prime_fill_a: assert property (is_dly && !primed_r |=>
		primed_r && buf_r[DEPTH-1] == $past(sec) && buf_r[0] == $past(sec))
		else $error("delay line not preloaded");
	shift_step_a: assert property (is_dly && primed_r && shift |=>
		acc_r == 32'h0 && buf_r[1] == $past(buf_r[0]) && buf_r[0] == $past(sec))
		else $error("delay line shift wrong");
	depth_range_a: assert property (depth >= 6'h01 && depth <= DEP_U
		&& period >= DT_U)
		else $error("delay depth or period out of range");
	interp_hold_a: assert property (is_dly && primed_r && !shift |=>
		acc_r == $past(acc_step) && acc_r < $past(period))
		else $error("interpolation phase wrong");

	cmp_seen_c: cover property (fire && req.code == OP_COMPARE ##1 stack_r.top == W'(ONE));
	lag_seen_c: cover property (is_lag ##2 fire ##2 fire ##2 is_lead);
	shift_seen_c: cover property (is_dly && primed_r && shift && depth == DEP_U);
	short_seen_c: cover property (is_dly && primed_r && per_short && depth > 6'h01);
endmodule

/* File: csl_pkg.sv */
// Shared constants and types for the compare, select, lag, lead and delay operations
package csl_pkg;
	localparam int W               = 24;
	localparam int DEPTH           = 40;
	localparam int LAG_INSTANCES   = 3;
	localparam int INTERVAL_MS_DEF = 100;
	localparam int ONE             = 1000;
	localparam int HALF            = 500;
	localparam int LAG_MS_PER_LSB  = 100;
	localparam int LAG_T_MAX       = 7999;
	localparam int DEAD_MS_PER_LSB = 1000;
	localparam int DEAD_T_MAX      = 2047000;
	localparam int DEAD_PER_MS_LSB = DEAD_MS_PER_LSB / DEPTH;

	typedef enum logic [2:0]
	{
		OP_NOP,
		OP_LOAD,
		OP_COMPARE,
		OP_SELECT,
		OP_LAG,
		OP_LEAD,
		OP_DELAY
	} csl_op_t;

	typedef struct packed
	{
		logic                valid;
		csl_op_t             code;
		logic [1:0]          inst;
		logic signed [W-1:0] value;
	} csl_req_t;

	typedef struct packed
	{
		logic signed [W-1:0] top;
		logic signed [W-1:0] second;
		logic signed [W-1:0] third;
	} csl_stack_t;
endpackage

/* File: csl_prog_model.sv */
// Program sequencer model that issues one operation request per call
module csl_prog_model (
	input  wire logic        mclk,
	output csl_pkg::csl_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	import csl_pkg::*;

	initial req = '0;

	// One call is one program step; each dynamic instance once per interval
	// Any operation code can be offered, including no-op as well as compare, select, lag, lead, delay and load
	task automatic issue(input csl_op_t c, input logic [1:0] n,
		input logic signed [W-1:0] v);
		@(posedge mclk);
		#1;
		req = '{1'b1, c, n, v};
		@(posedge mclk);
		#1;
		req.valid = 1'b0;
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the compare, select, lag, lead and delay operations
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import csl_pkg::*;
	logic       mclk;
	logic       srst;
	csl_req_t   req;
	csl_stack_t stack_r;
	logic       done_r;
	int         n_fail = 0;
	int         total_checks = 0;
	int         cycles = 0;
	int         a;
	int         b;
	int         s;
	int         lag_st[3] = '{0, 0, 0};
	int         lx[5] = '{1100, 8000, 8000, 1200, -700};
	int         lt[5] = '{10, 7999, 9000, 10, 0};
	int         dx[3] = '{1100, 8000, 500};
	int         dt[3] = '{10, 9000, 0};

	csl_dynamic_ops #(.INTERVAL_MS(100)) i_dut (.mclk(mclk), .srst(srst), .req(req),
		.stack_r(stack_r), .done_r(done_r));
	csl_prog_model i_prog (.mclk(mclk), .req(req));

	function automatic int lag_next(int st, int x, int t);
		int tc;
		tc = (t < 0) ? 0 : (t > LAG_T_MAX) ? LAG_T_MAX : t;
		return st + (x - st) * 100 / (tc * LAG_MS_PER_LSB + 100);
	endfunction

	task automatic end_sim();
		$display("Checks made: %0d, mismatches: %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic signed [W-1:0] got, input logic signed [W-1:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %0d, expected %0d", $time, got, exp);
		end
	endtask

	task automatic op(input csl_op_t c, input logic [1:0] n, input int v);
		i_prog.issue(c, n, v[W-1:0]);
		chk({{(W - 1){1'b0}}, done_r}, 1);
	endtask

	task automatic ld(input int v);
		op(OP_LOAD, 2'h0, v);
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			end_sim();
		end
	end

	initial
	begin
		srst = 1'b1;
		void'($urandom(32'h24f38c66));
		repeat (16) @(posedge mclk);
		#1;
		srst = 1'b0;
		ld(11);
		ld(22);
		ld(33);
		chk(stack_r.top, 33);
		chk(stack_r.second, 22);
		chk(stack_r.third, 11);
		op(OP_NOP, 2'h0, 0);
		op(OP_LAG, 2'h3, 0);
		chk(stack_r.top, 33);
		for (int i = 0; i < 24; i++)
		begin
			a = (i == 0) ? 700 : int'($urandom_range(0, 4000)) - 2000;
			b = (i == 0) ? 700 : int'($urandom_range(0, 4000)) - 2000;
			ld(a);
			ld(b);
			op(OP_COMPARE, 2'h0, 0);
			chk(stack_r.top, (b <= a) ? 1000 : 0);
			chk(stack_r.second, a);
		end
		for (int i = 0; i < 12; i++)
		begin
			s = (i < 2) ? 499 + i : int'($urandom_range(0, 1000));
			ld(i * 10 + 1);
			ld(i * 10 + 2);
			ld(s);
			op(OP_SELECT, 2'h0, 0);
			chk(stack_r.top, (s < HALF) ? i * 10 + 1 : i * 10 + 2);
		end
		for (int i = 0; i < 5; i++)
		begin
			ld(lx[i]);
			ld(lt[i]);
			op(OP_LAG, 2'(i % 3), 0);
			lag_st[i % 3] = lag_next(lag_st[i % 3], lx[i], lt[i]);
			chk(stack_r.top, lag_st[i % 3]);
		end
		for (int i = 0; i < 3; i++)
		begin
			ld(dx[i]);
			ld(dt[i]);
			op(OP_LEAD, 2'(i), 0);
			chk(stack_r.top, dx[i] - lag_next(0, dx[i], dt[i]));
		end
		ld(300);
		ld(1);
		op(OP_DELAY, 2'h0, 0);
		chk(stack_r.top, 300);
		for (int k = 2; k < 12; k++)
		begin
			ld(900);
			ld(1);
			op(OP_DELAY, 2'h0, 0);
			chk(stack_r.top, (k < 11) ? 300 : 900);
		end
		// Full-depth line, then a longer period so the tail is interpolated
		for (int k = 0; k < 31; k++)
		begin
			ld(900);
			ld((k < 29) ? 4 : 8);
			op(OP_DELAY, 2'h0, 0);
			a = (k < 29) ? 300 : 900;
			if (k == 29)
				a = 300 + (900 - 300) * 100 / (8 * DEAD_MS_PER_LSB / DEPTH);
			chk(stack_r.top, a);
		end
		// Reset in mid-run clears the stack and unprimes the delay line
		@(posedge mclk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		srst = 1'b0;
		chk(stack_r.top, 0);
		chk(stack_r.second, 0);
		ld(450);
		ld(4);
		op(OP_DELAY, 2'h0, 0);
		chk(stack_r.top, 450);
		ld(700);
		ld(4);
		op(OP_DELAY, 2'h0, 0);
		chk(stack_r.top, 450);
		end_sim();
	end
endmodule
